/* File: src/sld_pkg.sv */
// Constants for the segment display driver: register map, fields, levels
//
// Summary of operation
// (R1) Up to 27 frontplanes and 4 backplanes
// (R2) Arrangements 26x4, 27x3 and 27x1 supported
// (R3) Shared pin is frontplane zero or backplane three
// (R4) Two enables hand port pins to frontplanes
// (R5) Fourteen data registers, two frontplanes each
// (R6) Segment bit one drives on, zero off
// (R7) Disabled: all outputs at supply level
// (R8) Disabled: ladder disconnect control asserted
// (R9) Static duty drives backplane zero only
// (R10) One-third duty drives backplanes zero to two
// (R11) Quarter duty drives all four backplanes
// (R12) Enabled: backplane waveforms repeat continuously
// (R13) Third bias: supply, two thirds, third, bias
// (R14) Contrast field sets bottom ladder level
// (R15) Base clock is divided reference clock
// (R16) All transitions timed by base clock
// (R17) Frame spans duty count of base periods
// (R18) Enable is read/write, cleared by reset
// (R19) Shared pin is backplane only in quarter duty
// (R20) One backplane phase per base period
// (R21) On segment sees full supply, off sees third
package sld_pkg;
  localparam logic [7:0] SLD_CTRL_OFF = 8'h00;
  localparam logic [7:0] SLD_CLK_OFF = 8'h04;
  localparam logic [7:0] SLD_CFG_OFF = 8'h08;
  localparam logic [7:0] SLD_STAT_OFF = 8'h0c;
  localparam logic [7:0] SLD_DATA_OFF = 8'h10;
  localparam int SLD_NUM_DATA = 14;
  localparam int SLD_NUM_FP = 27;
  localparam int SLD_NUM_BP = 4;
  localparam int SLD_CTRL_EN_BIT = 0;
  localparam int SLD_CTRL_CON_LSB = 4;
  localparam int SLD_CON_W = 4;
  localparam int SLD_CLK_DIV_LSB = 0;
  localparam int SLD_CLK_DUTY_LSB = 4;
  localparam int SLD_CFG_LOW_BIT = 0;
  localparam int SLD_CFG_HIGH_BIT = 1;
  localparam logic [31:0] SLD_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SLD_CLK_RST = 32'h0000_0000;
  localparam logic [31:0] SLD_CFG_RST = 32'h0000_0000;
  localparam int SLD_PRE_W = 16;
  localparam logic [15:0] SLD_PRE_BASE = 16'h0080;
  typedef enum logic [1:0] {
    SLD_DUTY_STATIC = 2'b00,
    SLD_DUTY_THIRD = 2'b01,
    SLD_DUTY_QUARTER = 2'b10
  } sld_duty_type;
  // Drive level codes: supply, two thirds, one third, bias
  typedef enum logic [1:0] {
    SLD_LVL_VDD = 2'b00,
    SLD_LVL_V1 = 2'b01,
    SLD_LVL_V2 = 2'b10,
    SLD_LVL_V3 = 2'b11
  } sld_level_type;
endpackage

/* File: src/sld_base_clk.sv */
// Waveform base clock divider: one-cycle tick per base period
`timescale 1ns/10ps
`default_nettype none
module sld_base_clk
  import sld_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);
  logic [SLD_PRE_W+7:0] cnt_ff;
  logic [SLD_PRE_W+7:0] nxt_cnt;
  logic [SLD_PRE_W+7:0] limit;
  logic nxt_tick;
  always_comb begin
    limit = ({8'h00, SLD_PRE_BASE} << div_sel) - 24'h000001; // [R15]
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (!run) begin
      nxt_cnt = '0;
    end else if (cnt_ff >= limit) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 24'h000001;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
      tick <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick <= nxt_tick;
    end
  end
endmodule
`default_nettype wire

/* File: src/sld_phase_seq.sv */
// Backplane phase sequencer and polarity toggle
`timescale 1ns/10ps
`default_nettype none
module sld_phase_seq
  import sld_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic tick,
  input wire logic [1:0] duty,
  output logic [1:0] phase,
  output logic invert
);
  logic [1:0] nxt_phase;
  logic nxt_invert;
  logic [1:0] last;
  always_comb begin
    case (duty)
      SLD_DUTY_THIRD: last = 2'd2;
      SLD_DUTY_QUARTER: last = 2'd3;
      default: last = 2'd0;
    endcase
    nxt_phase = phase;
    nxt_invert = invert;
    if (!run) begin
      nxt_phase = 2'd0;
      nxt_invert = 1'b0;
    end else if (tick) begin
      if (phase >= last) begin // [R17]
        nxt_phase = 2'd0;
        nxt_invert = ~invert;
      end else begin
        nxt_phase = phase + 2'd1; // [R20]
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 2'd0;
      invert <= 1'b0;
    end else begin
      phase <= nxt_phase;
      invert <= nxt_invert;
    end
  end
endmodule
`default_nettype wire

/* File: src/sld_top.sv */
// Segment display driver: APB registers and plane level generation
`timescale 1ns/10ps
`default_nettype none
module sld_top
  import sld_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [2*SLD_NUM_BP-1:0] bp_level,
  output logic [2*SLD_NUM_FP-1:0] fp_level,
  output logic [7:0] port_pin_lcd_sel,
  output logic ladder_disconnect,
  output logic [SLD_CON_W-1:0] contrast_level
);
  logic display_drive_enable_ff;
  logic [SLD_CON_W-1:0] contrast_ff;
  logic [2:0] base_clock_divider_sel_ff;
  logic [1:0] duty_ff;
  logic low_shared_pin_enable_ff;
  logic high_shared_pin_enable_ff;
  logic [7:0] seg_ff [SLD_NUM_DATA];
  logic nxt_en;
  logic [SLD_CON_W-1:0] nxt_con;
  logic [2:0] nxt_div;
  logic [1:0] nxt_duty;
  logic nxt_low;
  logic nxt_high;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic wr;
  logic rd;
  logic [5:0] widx;
  logic hit_data;
  logic tick;
  logic [1:0] phase;
  logic invert;
  logic [3:0] segs [SLD_NUM_FP];
  logic [2*SLD_NUM_BP-1:0] nxt_bp;
  logic [2*SLD_NUM_FP-1:0] nxt_fp;
  logic [3:0] bp_used;
  logic fp0_is_bp3;

  sld_base_clk u_base (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(display_drive_enable_ff),
    .div_sel(base_clock_divider_sel_ff),
    .tick(tick)
  );
  sld_phase_seq u_seq (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(display_drive_enable_ff),
    .tick(tick), // [R16]
    .duty(duty_ff),
    .phase(phase),
    .invert(invert)
  );

  // Register access decode
  always_comb begin
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    widx = 6'(paddr[7:2] - SLD_DATA_OFF[7:2]);
    hit_data = (paddr >= SLD_DATA_OFF) && (widx < 6'(SLD_NUM_DATA)) && (paddr[1:0] == 2'b00);
    nxt_en = display_drive_enable_ff;
    nxt_con = contrast_ff;
    nxt_div = base_clock_divider_sel_ff;
    nxt_duty = duty_ff;
    nxt_low = low_shared_pin_enable_ff;
    nxt_high = high_shared_pin_enable_ff;
    nxt_err = 1'b0;
    nxt_rdata = prdata;
    if (wr) begin
      case (paddr)
        SLD_CTRL_OFF: begin
          nxt_en = pwdata[SLD_CTRL_EN_BIT]; // [R18]
          nxt_con = pwdata[SLD_CTRL_CON_LSB +: SLD_CON_W]; // [R14]
        end
        SLD_CLK_OFF: begin
          nxt_div = pwdata[SLD_CLK_DIV_LSB +: 3]; // [R15]
          if (pwdata[SLD_CLK_DUTY_LSB +: 2] != 2'b11) begin
            nxt_duty = pwdata[SLD_CLK_DUTY_LSB +: 2]; // [R2]
          end
        end
        SLD_CFG_OFF: begin
          nxt_low = pwdata[SLD_CFG_LOW_BIT]; // [R4]
          nxt_high = pwdata[SLD_CFG_HIGH_BIT]; // [R4]
        end
        SLD_STAT_OFF: nxt_err = 1'b0;
        default: nxt_err = !hit_data;
      endcase
    end
    if (rd) begin
      nxt_rdata = 32'h0000_0000;
      case (paddr)
        SLD_CTRL_OFF: begin
          nxt_rdata[SLD_CTRL_EN_BIT] = display_drive_enable_ff;
          nxt_rdata[SLD_CTRL_CON_LSB +: SLD_CON_W] = contrast_ff;
        end
        SLD_CLK_OFF: begin
          nxt_rdata[SLD_CLK_DIV_LSB +: 3] = base_clock_divider_sel_ff;
          nxt_rdata[SLD_CLK_DUTY_LSB +: 2] = duty_ff;
        end
        SLD_CFG_OFF: begin
          nxt_rdata[SLD_CFG_LOW_BIT] = low_shared_pin_enable_ff;
          nxt_rdata[SLD_CFG_HIGH_BIT] = high_shared_pin_enable_ff;
        end
        SLD_STAT_OFF: nxt_rdata = {27'h0, invert, phase, tick, display_drive_enable_ff};
        default: begin
          if (hit_data) begin
            nxt_rdata = {24'h0, seg_ff[widx[3:0]]};
          end
        end
      endcase
    end
    // Flag an unmapped address in setup so pslverr stands through the access phase
    if (psel && !penable) begin
      nxt_err = !(hit_data || paddr == SLD_CTRL_OFF || paddr == SLD_CLK_OFF ||
        paddr == SLD_CFG_OFF || paddr == SLD_STAT_OFF);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      display_drive_enable_ff <= SLD_CTRL_RST[SLD_CTRL_EN_BIT]; // [R18]
      contrast_ff <= SLD_CTRL_RST[SLD_CTRL_CON_LSB +: SLD_CON_W];
      base_clock_divider_sel_ff <= SLD_CLK_RST[SLD_CLK_DIV_LSB +: 3];
      duty_ff <= SLD_CLK_RST[SLD_CLK_DUTY_LSB +: 2];
      low_shared_pin_enable_ff <= SLD_CFG_RST[SLD_CFG_LOW_BIT];
      high_shared_pin_enable_ff <= SLD_CFG_RST[SLD_CFG_HIGH_BIT];
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      display_drive_enable_ff <= nxt_en;
      contrast_ff <= nxt_con;
      base_clock_divider_sel_ff <= nxt_div;
      duty_ff <= nxt_duty;
      low_shared_pin_enable_ff <= nxt_low;
      high_shared_pin_enable_ff <= nxt_high;
      prdata <= nxt_rdata;
      pslverr <= (psel && !penable) ? nxt_err : (wr ? nxt_err : pslverr);
    end
  end

  // Access phase always completes in one cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Segment data, two frontplanes per register, four backplanes each
  genvar g;
  generate
    for (g = 0; g < SLD_NUM_DATA; g++) begin : g_seg
      logic [7:0] nxt_seg;
      always_comb begin
        nxt_seg = seg_ff[g];
        if (wr && hit_data && widx == 6'(g)) begin
          nxt_seg = pwdata[7:0]; // [R5]
        end
      end
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          seg_ff[g] <= 8'h00;
        end else begin
          seg_ff[g] <= nxt_seg;
        end
      end
    end
    for (g = 0; g < SLD_NUM_FP; g++) begin : g_map
      assign segs[g] = (g % 2 == 0) ? seg_ff[g/2][3:0] : seg_ff[g/2][7:4]; // [R1]
    end
  endgenerate

  // Level generation: selected backplane toggles VDD and bias, other used ones sit at thirds, unused ones at VDD
  always_comb begin
    fp0_is_bp3 = (duty_ff == SLD_DUTY_QUARTER); // [R3] [R19]
    case (duty_ff)
      SLD_DUTY_THIRD: bp_used = 4'b0111; // [R10]
      SLD_DUTY_QUARTER: bp_used = 4'b1111; // [R11]
      default: bp_used = 4'b0001; // [R9]
    endcase
    nxt_bp = '0;
    nxt_fp = '0;
    for (int b = 0; b < SLD_NUM_BP; b++) begin
      if (!display_drive_enable_ff) begin
        nxt_bp[2*b +: 2] = SLD_LVL_VDD; // [R7]
      end else if (!bp_used[b]) begin
        nxt_bp[2*b +: 2] = SLD_LVL_VDD;
      end else if (duty_ff == SLD_DUTY_STATIC || phase == 2'(b)) begin
        nxt_bp[2*b +: 2] = invert ? SLD_LVL_V3 : SLD_LVL_VDD; // [R12] [R13]
      end else begin
        nxt_bp[2*b +: 2] = invert ? SLD_LVL_V1 : SLD_LVL_V2;
      end
    end
    for (int f = 0; f < SLD_NUM_FP; f++) begin
      if (!display_drive_enable_ff) begin
        nxt_fp[2*f +: 2] = SLD_LVL_VDD; // [R7]
      end else if (duty_ff == SLD_DUTY_STATIC) begin
        nxt_fp[2*f +: 2] = (segs[f][0] ^ invert) ? SLD_LVL_V3 : SLD_LVL_VDD; // [R6]
      end else if (segs[f][phase]) begin
        nxt_fp[2*f +: 2] = invert ? SLD_LVL_VDD : SLD_LVL_V3; // [R21]
      end else begin
        nxt_fp[2*f +: 2] = invert ? SLD_LVL_V2 : SLD_LVL_V1; // [R21]
      end
    end
    if (fp0_is_bp3) begin
      nxt_fp[1:0] = nxt_bp[7:6]; // [R3]
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bp_level <= '0;
      fp_level <= '0;
      port_pin_lcd_sel <= 8'h00;
      ladder_disconnect <= 1'b1;
      contrast_level <= '0;
    end else begin
      bp_level <= nxt_bp;
      fp_level <= nxt_fp;
      port_pin_lcd_sel <= {{4{high_shared_pin_enable_ff}}, {4{low_shared_pin_enable_ff}}}; // [R4]
      ladder_disconnect <= !display_drive_enable_ff; // [R8]
      contrast_level <= contrast_ff; // [R14]
    end
  end
endmodule
`default_nettype wire

/* File: verification/sld_lcd_panel.sv */
// Passive segment panel model: latches every segment that sees full drive
`timescale 1ns/10ps
`default_nettype none
module sld_lcd_panel
  import sld_pkg::*;
(
  input wire logic core_clk,
  input wire logic clr,
  input wire logic [2*SLD_NUM_BP-1:0] bp_level,
  input wire logic [2*SLD_NUM_FP-1:0] fp_level,
  output logic [4*SLD_NUM_FP-1:0] seen
);
  logic [1:0] b_lv;
  logic [1:0] f_lv;
  // Full supply across a segment only when one side is at supply, the other at bias
  always_ff @(posedge core_clk) begin
    if (clr) begin
      seen <= '0;
    end else begin
      for (int f = 0; f < SLD_NUM_FP; f++) begin
        for (int b = 0; b < SLD_NUM_BP; b++) begin
          b_lv = bp_level[2*b+:2];
          f_lv = fp_level[2*f+:2];
          if ((b_lv == SLD_LVL_VDD && f_lv == SLD_LVL_V3) ||
              (b_lv == SLD_LVL_V3 && f_lv == SLD_LVL_VDD)) begin
            seen[f*4+b] <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/sld_top_chk.sv */
// Port checker for the segment display driver
`timescale 1ns/10ps
`default_nettype none
module sld_top_chk
  import sld_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2*SLD_NUM_BP-1:0] bp_level,
  input wire logic [2*SLD_NUM_FP-1:0] fp_level,
  input wire logic [7:0] port_pin_lcd_sel,
  input wire logic ladder_disconnect,
  input wire logic [SLD_CON_W-1:0] contrast_level
);
  localparam int MAX_GAP = 16400;
  logic [15:0] gap_ff;
  logic [15:0] nxt_gap;
  logic [2*SLD_NUM_BP-1:0] bp_ff;
  logic lad_ff;
  logic wr_ctrl;
  logic wr_cfg;
  assign wr_ctrl = psel && penable && pwrite && paddr == SLD_CTRL_OFF;
  assign wr_cfg = psel && penable && pwrite && paddr == SLD_CFG_OFF;
  // Cycles since the backplanes or the ladder control last moved
  always_comb begin
    nxt_gap = gap_ff;
    if (bp_level != bp_ff || ladder_disconnect != lad_ff) begin
      nxt_gap = 16'h0000;
    end else if (gap_ff != 16'hffff) begin
      nxt_gap = gap_ff + 16'h0001;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gap_ff <= 16'h0000;
      bp_ff <= '0;
      lad_ff <= 1'b1;
    end else begin
      gap_ff <= nxt_gap;
      bp_ff <= bp_level;
      lad_ff <= ladder_disconnect;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_unmap;
    psel && penable && paddr > 8'h44 |-> pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not flagged");
  property p_dis_vdd;
    ladder_disconnect && $past(ladder_disconnect) |-> bp_level == '0 && fp_level == '0;
  endproperty
  a_dis_vdd: assert property (p_dis_vdd) else $error("outputs off supply while off");
  property p_en_src;
    $fell(ladder_disconnect) |-> $past(wr_ctrl) || $past(wr_ctrl, 2);
  endproperty
  a_en_src: assert property (p_en_src) else $error("ladder joined without write");
  property p_con_src;
    $changed(contrast_level) |-> $past(wr_ctrl) || $past(wr_ctrl, 2);
  endproperty
  a_con_src: assert property (p_con_src) else $error("contrast moved without write");
  property p_sel_src;
    $changed(port_pin_lcd_sel) |-> $past(wr_cfg) || $past(wr_cfg, 2);
  endproperty
  a_sel_src: assert property (p_sel_src) else $error("pin select moved alone");
  property p_min;
    $changed(bp_level) && !ladder_disconnect && !$past(ladder_disconnect) |-> gap_ff >= 16'd120;
  endproperty
  a_min: assert property (p_min) else $error("backplane phase too short");
  property p_live;
    !ladder_disconnect |-> gap_ff < MAX_GAP;
  endproperty
  a_live: assert property (p_live) else $error("backplanes stopped");
endmodule
bind sld_top sld_top_chk chk_u (.core_clk(core_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bp_level(bp_level), .fp_level(fp_level),
  .port_pin_lcd_sel(port_pin_lcd_sel), .ladder_disconnect(ladder_disconnect),
  .contrast_level(contrast_level));
`default_nettype wire

/* File: verification/sld_top_tb.sv */
// Self-checking bench for the segment display driver
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, s); end end
module sld_top_tb
  import sld_pkg::*;
;
  logic core_clk, resetn, psel, penable, pwrite, clr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, rs, r32;
  logic pready, pslverr, ladder_disconnect;
  logic [7:0] bp_level, port_pin_lcd_sel;
  logic [53:0] fp_level;
  logic [107:0] seen;
  logic [3:0] contrast_level, con;
  logic [7:0] dat [14];
  int failures, checked;
  always #20 core_clk = ~core_clk;
  sld_top dut_u (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bp_level(bp_level), .fp_level(fp_level),
    .port_pin_lcd_sel(port_pin_lcd_sel), .ladder_disconnect(ladder_disconnect),
    .contrast_level(contrast_level));
  sld_lcd_panel pnl_u (.core_clk(core_clk), .clr(clr), .bp_level(bp_level),
    .fp_level(fp_level), .seen(seen));
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [107:0] exp_seen(input int d, input logic mk);
    logic [107:0] r;
    r = '0;
    for (int f = 0; f < 27; f++) for (int b = 0; b < 4; b++) begin
      if (d == 0 ? b == 0 : d == 1 ? b < 3 : f != 0) r[f*4+b] = mk | dat[f/2][(f%2)*4+b];
    end
    return r;
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 64);
    if (n >= 64) failures++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Registered outputs follow the register one edge later; sample them settled
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    core_clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    clr = 1; failures = 0; checked = 0; rs = 32'd36430;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    `CHK("ladder_rst", 1'b1, ladder_disconnect)
    `CHK("bp_rst", 8'h00, bp_level)
    @(posedge core_clk);
    apb(1'b0, SLD_CTRL_OFF, 32'h0);
    `CHK("ctrl_rst", SLD_CTRL_RST, q)
    apb(1'b1, 8'h48, 32'h1);
    `CHK("unmapped", 1'b1, e)
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, SLD_CFG_OFF, 32'(i));
      `CHK("port_sel", {{4{i[1]}}, {4{i[0]}}}, port_pin_lcd_sel)
    end
    for (int i = 0; i < 14; i++) begin
      r32 = rnd();
      dat[i] = (i == 0) ? 8'hff : r32[7:0];
      apb(1'b1, SLD_DATA_OFF + 8'(4*i), {24'h0, dat[i]});
    end
    apb(1'b0, SLD_DATA_OFF + 8'h0c, 32'h0);
    `CHK("data_rd", dat[3], q[7:0])
    for (int d = 0; d < 3; d++) begin
      clr <= 1'b1;
      apb(1'b1, SLD_CTRL_OFF, 32'h0);
      @(posedge core_clk);
      `CHK("fp_off", 54'h0, fp_level)
      `CHK("ladder_off", 1'b1, ladder_disconnect)
      apb(1'b1, SLD_CLK_OFF, {26'h0, 2'(d), 1'b0, 3'(d)});
      r32 = rnd();
      con = r32[3:0];
      apb(1'b1, SLD_CTRL_OFF, {24'h0, con, 4'h1});
      clr <= 1'b0;
      `CHK("contrast", con, contrast_level)
      repeat ((128 << d) * 8 + 20) @(posedge core_clk);
      `CHK("ladder_on", 1'b0, ladder_disconnect)
      `CHK("segments", exp_seen(d, 1'b0), seen & exp_seen(d, 1'b1))
    end
    apb(1'b1, SLD_CLK_OFF, 32'h30);
    apb(1'b0, SLD_CLK_OFF, 32'h0);
    `CHK("duty_refused", 2'b10, q[5:4])
    final_report;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
